//--- src/sol_strap_latch.sv
// strap option latch: captures dual-use pins in reset, apb view of the result
//
// Behaviour
// - sample straps only while reset is active
// - latch four pins as address bits 4:1
// - address bit 0 is port number
// - port A even, port B odd addresses
// - open address pins read zero
// - fiber strap high selects 100 fiber mode
// - an strap high: negotiate, advertise mode selects
// - an strap low: force speed and duplex
// - fiber: low mode select picks duplex
// - fiber: ignore an and high mode select
// - load straps into control and advertisement
// - every pin reset re-captures and reinitialises
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "sol_strap_map.svh"

module sol_strap_latch
    import sol_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   rst_b,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`SOL_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [`SOL_PIN_W-1:0]  strapPinIn,
    input  wire logic [`SOL_PIN_W-1:0]  funcPinOut,
    output logic      [`SOL_PIN_W-1:0]  strapPinOut,
    output logic      [`SOL_PIN_W-1:0]  strapPinOeB,
    output sol_port_cfg_t [1:0]         portCfg,
    output logic                        strapValid
);

    // pin synchroniser, no reset so the pins are seen during reset
    logic [`SOL_PIN_W-1:0] syncAReg;
    logic [`SOL_PIN_W-1:0] syncBReg;

    // captured straps and sequencing
    logic [3:0]            addrCapReg;
    logic [3:0]            addrCapNext;
    sol_port_strap_t [1:0] strapCapReg;
    sol_port_strap_t [1:0] strapCapNext;
    sol_state_t            stateReg;
    sol_state_t            stateNext;
    // reset length in unary: shifts in ones, so no power-up value is needed
    localparam int RESET_MIN_CYC = `SOL_RESET_MIN_CYC;
    logic [RESET_MIN_CYC-1:0] rstCntReg;
    logic [RESET_MIN_CYC-1:0] rstCntNext;
    logic                  validReg;
    logic                  validNext;

    // per-port programmable copies
    logic [1:0][15:0]      bmcrReg;
    logic [1:0][15:0]      bmcrNext;
    logic [1:0][15:0]      anarReg;
    logic [1:0][15:0]      anarNext;
    logic [1:0][15:0]      bmcrInit;
    logic [1:0][15:0]      anarInit;
    sol_port_cfg_t [1:0]   cfgReg;
    sol_port_cfg_t [1:0]   cfgNext;

    // pins and bus
    logic [`SOL_PIN_W-1:0] pinOutReg;
    logic [`SOL_PIN_W-1:0] pinOutNext;
    logic [`SOL_PIN_W-1:0] pinOeBReg;
    logic [`SOL_PIN_W-1:0] pinOeBNext;
    logic [31:0]           rdataReg;
    logic [31:0]           rdataNext;
    logic                  readyReg;
    logic                  readyNext;
    logic                  errReg;
    logic                  errNext;
    logic [31:0]           readMux;
    logic                  mapped;
    logic                  wrDone;

    always_ff @(posedge mclk) begin
        syncAReg <= strapPinIn;
        syncBReg <= syncAReg;
    end

    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++) begin : g_port
            sol_strap_decode u_decode (
                .strap    (strapCapReg[gp]),
                .bmcrInit (bmcrInit[gp]),
                .anarInit (anarInit[gp])
            );
        end
    endgenerate

    // capture and sequencing
    always_comb begin
        addrCapNext  = addrCapReg;
        strapCapNext = strapCapReg;
        stateNext    = stateReg;
        rstCntNext   = rstCntReg;
        validNext    = validReg;
        if (!rst_b) begin
            // follow the pins for the whole reset, freeze at release
            addrCapNext = syncBReg[`SOL_PIN_ADDR_LO +: 4];
            strapCapNext[0] = {syncBReg[`SOL_PIN_FIBER_A], syncBReg[`SOL_PIN_AN_A],
                               syncBReg[`SOL_PIN_MODE_HI_A],
                               syncBReg[`SOL_PIN_MODE_LO_A]};
            strapCapNext[1] = {syncBReg[`SOL_PIN_FIBER_B], syncBReg[`SOL_PIN_AN_B],
                               syncBReg[`SOL_PIN_MODE_HI_B],
                               syncBReg[`SOL_PIN_MODE_LO_B]};
            stateNext = SOL_ST_CAPTURE;
            validNext = 1'b0;
            rstCntNext = {rstCntReg[RESET_MIN_CYC-2:0], 1'b1};
        end else begin
            rstCntNext = '0;
            case (stateReg)
                SOL_ST_CAPTURE: begin
                    stateNext = SOL_ST_LOAD;
                    // a reset shorter than the minimum may leave a stale capture
                    validNext = &rstCntReg;
                end
                SOL_ST_LOAD: stateNext = SOL_ST_RUN;
                SOL_ST_RUN:  stateNext = SOL_ST_RUN;
                default:     stateNext = SOL_ST_CAPTURE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        addrCapReg  <= addrCapNext;
        strapCapReg <= strapCapNext;
        stateReg    <= stateNext;
        rstCntReg   <= rstCntNext;
        validReg    <= validNext;
    end

    // bus decode
    assign wrDone = psel & penable & readyReg & pwrite;

    always_comb begin
        mapped  = 1'b1;
        readMux = 32'h0000_0000;
        case (paddr)
            `SOL_OFS_CTRL_A: begin
                readMux[`SOL_CTRL_ADDR_LSB +: 5]  = cfgReg[0].mgmtAddr;
                readMux[`SOL_CTRL_FIBER]          = cfgReg[0].fiber;
                readMux[`SOL_CTRL_STRAP_LSB +: 4] = strapCapReg[0];
            end
            `SOL_OFS_CTRL_B: begin
                readMux[`SOL_CTRL_ADDR_LSB +: 5]  = cfgReg[1].mgmtAddr;
                readMux[`SOL_CTRL_FIBER]          = cfgReg[1].fiber;
                readMux[`SOL_CTRL_STRAP_LSB +: 4] = strapCapReg[1];
            end
            `SOL_OFS_BMCR_A: readMux[15:0] = bmcrReg[0];
            `SOL_OFS_BMCR_B: readMux[15:0] = bmcrReg[1];
            `SOL_OFS_ANAR_A: readMux[15:0] = anarReg[0];
            `SOL_OFS_ANAR_B: readMux[15:0] = anarReg[1];
            `SOL_OFS_STATUS: begin
                readMux[`SOL_STAT_VALID] = validReg;
                readMux[`SOL_STAT_RUN]   = (stateReg == SOL_ST_RUN);
            end
            default: mapped = 1'b0;
        endcase
    end

    // one wait-free access phase: answer registered during setup
    always_comb begin
        readyNext = 1'b0;
        errNext   = 1'b0;
        rdataNext = 32'h0000_0000;
        if (rst_b && psel && !penable) begin
            readyNext = 1'b1;
            errNext   = ~mapped;
            rdataNext = pwrite ? 32'h0000_0000 : readMux;
        end
    end

    always_ff @(posedge mclk) begin
        readyReg <= readyNext;
        errReg   <= errNext;
        rdataReg <= rdataNext;
    end

    // programmable control and advertisement per port
    always_comb begin
        bmcrNext = bmcrReg;
        anarNext = anarReg;
        for (int p = 0; p < 2; p++) begin
            if (!rst_b) begin
                bmcrNext[p] = 16'h0000;
                anarNext[p] = `SOL_ANAR_SELECTOR;
            end else if (stateReg == SOL_ST_LOAD) begin
                // one load from the frozen capture, never from live pins
                bmcrNext[p] = bmcrInit[p];
                anarNext[p] = anarInit[p];
            end else if (wrDone && paddr == (p == 0 ? `SOL_OFS_BMCR_A
                                                    : `SOL_OFS_BMCR_B)) begin
                if (pwdata[`SOL_BMCR_SOFT_RST]) begin
                    // soft reset restores strapped values without re-sampling
                    bmcrNext[p] = bmcrInit[p];
                    anarNext[p] = anarInit[p];
                end else begin
                    bmcrNext[p] = pwdata[15:0] & `SOL_BMCR_WMASK;
                    if (strapCapReg[p].fiber) begin
                        bmcrNext[p][`SOL_BMCR_AUTONEG_ENABLE_STRAP] = 1'b0;
                        bmcrNext[p][`SOL_BMCR_SPEED] = 1'b1;
                    end
                end
            end else if (wrDone && paddr == (p == 0 ? `SOL_OFS_ANAR_A
                                                    : `SOL_OFS_ANAR_B)) begin
                anarNext[p] = (pwdata[15:0] & `SOL_ANAR_WMASK) | `SOL_ANAR_SELECTOR;
            end
        end
    end

    always_ff @(posedge mclk) begin
        bmcrReg <= bmcrNext;
        anarReg <= anarNext;
    end

    // configuration handed to the port logic
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            cfgNext[p].mgmtAddr   = {addrCapReg, p[0]};
            cfgNext[p].fiber      = strapCapReg[p].fiber;
            cfgNext[p].anEn       = bmcrNext[p][`SOL_BMCR_AUTONEG_ENABLE_STRAP];
            cfgNext[p].speed100   = bmcrNext[p][`SOL_BMCR_SPEED];
            cfgNext[p].fullDuplex = bmcrNext[p][`SOL_BMCR_DUPLEX];
        end
        if (!rst_b) begin
            cfgNext = '0;
        end
    end

    always_ff @(posedge mclk) begin
        cfgReg <= cfgNext;
    end

    // shared pins stay released until configuration is frozen
    always_comb begin
        pinOutNext = pinOutReg;
        pinOeBNext = pinOeBReg;
        if (!rst_b || stateReg == SOL_ST_CAPTURE) begin
            pinOutNext = '0;
            pinOeBNext = '1;
        end else if (stateReg == SOL_ST_RUN) begin
            pinOutNext = funcPinOut;
            pinOeBNext = '0;
        end
    end

    always_ff @(posedge mclk) begin
        pinOutReg <= pinOutNext;
        pinOeBReg <= pinOeBNext;
    end

    assign prdata      = rdataReg;
    assign pready      = readyReg;
    assign pslverr     = errReg;
    assign strapPinOut = pinOutReg;
    assign strapPinOeB = pinOeBReg;
    assign portCfg     = cfgReg;
    assign strapValid  = validReg;

endmodule : sol_strap_latch

//--- src/sol_strap_map.svh
// offsets, field positions, reset values and timing counts of the strap option latch
`ifndef SOL_STRAP_MAP_SVH
`define SOL_STRAP_MAP_SVH

// apb register byte addresses
`define SOL_ADDR_W          8
`define SOL_OFS_CTRL_A      8'h00
`define SOL_OFS_BMCR_A      8'h04
`define SOL_OFS_ANAR_A      8'h08
`define SOL_OFS_CTRL_B      8'h10
`define SOL_OFS_BMCR_B      8'h14
`define SOL_OFS_ANAR_B      8'h18
`define SOL_OFS_STATUS      8'h20

// strap pin positions on the shared pin vector
`define SOL_PIN_W           12
`define SOL_PIN_ADDR_LO     0
`define SOL_PIN_FIBER_A     4
`define SOL_PIN_FIBER_B     5
`define SOL_PIN_AN_A        6
`define SOL_PIN_MODE_HI_A   7
`define SOL_PIN_MODE_LO_A   8
`define SOL_PIN_AN_B        9
`define SOL_PIN_MODE_HI_B   10
`define SOL_PIN_MODE_LO_B   11

// unstrapped levels: address pulled down, fiber down, an and mode up
`define SOL_PIN_DEFAULT     12'h0_FC0
`define SOL_STRAP_DEFAULT   4'h7

// control register fields
`define SOL_CTRL_ADDR_LSB   0
`define SOL_CTRL_FIBER      8
`define SOL_CTRL_STRAP_LSB  12

// basic mode control fields
`define SOL_BMCR_SOFT_RST   15
`define SOL_BMCR_SPEED      13
`define SOL_BMCR_AUTONEG_ENABLE_STRAP      12
`define SOL_BMCR_AN_RESTART 9
`define SOL_BMCR_DUPLEX     8
`define SOL_BMCR_WMASK      16'h3100

// advertisement fields
`define SOL_ANAR_100FD      8
`define SOL_ANAR_100HD      7
`define SOL_ANAR_10FD       6
`define SOL_ANAR_10HD       5
`define SOL_ANAR_SELECTOR   16'h0001
`define SOL_ANAR_WMASK      16'h01E0

// status fields
`define SOL_STAT_VALID      0
`define SOL_STAT_RUN        1

// timing
`define SOL_CLK_NS          50
`define SOL_RESET_MIN_NS    1000
`define SOL_RESET_MIN_CYC   ((`SOL_RESET_MIN_NS + `SOL_CLK_NS - 1) / `SOL_CLK_NS)
`define SOL_CNT_W           5

`endif

//--- src/sol_pkg.sv
// types shared by the strap option latch files
package sol_pkg;

    typedef struct packed {
        logic fiber;
        logic anEn;
        logic modeHi;
        logic modeLo;
    } sol_port_strap_t;

    typedef struct packed {
        logic [4:0] mgmtAddr;
        logic       fiber;
        logic       anEn;
        logic       speed100;
        logic       fullDuplex;
    } sol_port_cfg_t;

    typedef enum logic [1:0] {
        SOL_ST_CAPTURE = 2'b00,
        SOL_ST_LOAD    = 2'b01,
        SOL_ST_RUN     = 2'b11
    } sol_state_t;

endpackage : sol_pkg

//--- src/sol_strap_decode.sv
// turns one port's captured straps into control and advertisement values
`timescale 1ns/1ps
`include "sol_strap_map.svh"

module sol_strap_decode
    import sol_pkg::*;
(
    input  sol_port_strap_t strap,
    output logic [15:0]     bmcrInit,
    output logic [15:0]     anarInit
);

    always_comb begin
        bmcrInit = 16'h0000;
        anarInit = `SOL_ANAR_SELECTOR;
        if (strap.fiber) begin
            // fiber has no negotiation: force 100, duplex from low select
            bmcrInit[`SOL_BMCR_SPEED]  = 1'b1;
            bmcrInit[`SOL_BMCR_DUPLEX] = strap.modeLo;
            bmcrInit[`SOL_BMCR_AUTONEG_ENABLE_STRAP]  = 1'b0;
            anarInit[`SOL_ANAR_100FD]  = strap.modeLo;
            anarInit[`SOL_ANAR_100HD]  = ~strap.modeLo;
        end else if (strap.anEn) begin
            bmcrInit[`SOL_BMCR_AUTONEG_ENABLE_STRAP]  = 1'b1;
            bmcrInit[`SOL_BMCR_SPEED]  = 1'b1;
            bmcrInit[`SOL_BMCR_DUPLEX] = 1'b1;
            case ({strap.modeHi, strap.modeLo})
                2'b00: anarInit[`SOL_ANAR_10HD] = 1'b1;
                2'b01: anarInit[`SOL_ANAR_10FD] = 1'b1;
                2'b10: anarInit[`SOL_ANAR_100HD] = 1'b1;
                default: anarInit = anarInit | `SOL_ANAR_WMASK;
            endcase
        end else begin
            bmcrInit[`SOL_BMCR_SPEED]  = strap.modeHi;
            bmcrInit[`SOL_BMCR_DUPLEX] = strap.modeLo;
            anarInit[`SOL_ANAR_10HD]   = ~strap.modeHi & ~strap.modeLo;
            anarInit[`SOL_ANAR_10FD]   = ~strap.modeHi & strap.modeLo;
            anarInit[`SOL_ANAR_100HD]  = strap.modeHi & ~strap.modeLo;
            anarInit[`SOL_ANAR_100FD]  = strap.modeHi & strap.modeLo;
        end
    end

endmodule : sol_strap_decode

//--- bench/sol_strap_latch_assertions.sv
// concurrent checks on the strap option latch ports
`timescale 1ns/1ps

module sol_strap_latch_assertions
    import sol_pkg::*;
(
    input wire logic              mclk,
    input wire logic              rst_b,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [11:0]       strapPinIn,
    input wire logic [11:0]       funcPinOut,
    input wire logic [11:0]       strapPinOut,
    input wire logic [11:0]       strapPinOeB,
    input wire sol_port_cfg_t [1:0] portCfg,
    input wire logic              strapValid
);
    logic [19:0] lowHist_reg;
    logic [19:0] lowHist_next;
    logic [1:0]  runCnt_reg;
    logic [1:0]  runCnt_next;

    // last twenty reset samples, known after twenty edges whatever the power-up value
    always_comb begin
        lowHist_next = {lowHist_reg[18:0], !rst_b};
        runCnt_next  = !rst_b ? 2'h0 : runCnt_reg + 2'(runCnt_reg != 2'h3);
    end

    always_ff @(posedge mclk) begin
        lowHist_reg <= lowHist_next;
        runCnt_reg  <= runCnt_next;
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    chk_port_bit: assert property (runCnt_reg != 2'h0 |->
        !portCfg[0].mgmtAddr[0] && portCfg[1].mgmtAddr[0])
        else $error("address bit 0 does not match port");
    chk_upper_shared: assert property (runCnt_reg != 2'h0 |->
        portCfg[0].mgmtAddr[4:1] == portCfg[1].mgmtAddr[4:1])
        else $error("ports disagree on upper address");
    chk_cfg_hold: assert property (runCnt_reg >= 2'h2 |->
        $stable({portCfg[0].mgmtAddr, portCfg[0].fiber, portCfg[1].mgmtAddr, portCfg[1].fiber}))
        else $error("captured straps changed after release");
    chk_fiber_mode: assert property (runCnt_reg >= 2'h2 |->
        (!portCfg[0].fiber || (portCfg[0].speed100 && !portCfg[0].anEn)) &&
        (!portCfg[1].fiber || (portCfg[1].speed100 && !portCfg[1].anEn)))
        else $error("fiber port not forced to 100 without negotiation");
    chk_pins_held: assert property (runCnt_reg == 2'h1 |-> &strapPinOeB)
        else $error("pins driven right after release");
    chk_pins_driven: assert property (runCnt_reg == 2'h3 |-> strapPinOeB == 12'h000)
        else $error("pins not driven in run");
    chk_func_drive: assert property (runCnt_reg == 2'h3 |=>
        strapPinOut == $past(funcPinOut))
        else $error("pin drive does not follow functional value");
    chk_valid_len: assert property (rst_b && !$past(rst_b) |=>
        strapValid == (&$past(lowHist_reg)))
        else $error("valid flag disagrees with reset length");
    chk_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("access phase answer not one cycle");

    cover property (rst_b && !$past(rst_b) ##1 strapValid);
    cover property (runCnt_reg == 2'h3 && portCfg[1].fiber);
    cover property (pready && pslverr);
endmodule : sol_strap_latch_assertions

bind sol_strap_latch sol_strap_latch_assertions i_chk (.mclk(mclk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .strapPinIn(strapPinIn),
    .funcPinOut(funcPinOut), .strapPinOut(strapPinOut), .strapPinOeB(strapPinOeB),
    .portCfg(portCfg), .strapValid(strapValid));

//--- bench/sol_strap_latch_tb.sv
// self-checking bench for the strap option latch
`timescale 1ns/1ps
`include "sol_strap_map.svh"

module sol_strap_latch_tb import sol_pkg::*;;
    logic                mclk, rst_b, psel, penable, pwrite, pready, pslverr, strapValid;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata;
    logic [11:0]         strapPinIn, funcPinOut, strapPinOut, strapPinOeB;
    sol_port_cfg_t [1:0] portCfg;
    int                  err_total, checked;

    sol_strap_latch i_dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .strapPinIn(strapPinIn), .funcPinOut(funcPinOut),
        .strapPinOut(strapPinOut), .strapPinOeB(strapPinOeB), .portCfg(portCfg),
        .strapValid(strapValid));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk_reg(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk_reg

    task automatic chk_cfg(string nm, logic [8:0] e, sol_port_cfg_t g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk_cfg

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    // waits on pready, so the slave's latency is never assumed
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] q,
                       output logic er);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] q;
        logic        er;
        apb(1'b1, a, d, q, er);
    endtask : wr

    task automatic rd(string nm, logic [7:0] a, logic [31:0] e, logic ee);
        logic [31:0] q;
        logic        er;
        apb(1'b0, a, 32'h0000_0000, q, er);
        chk_reg(nm, e, q);
        chk_reg({nm, " error"}, 32'(ee), 32'(er));
    endtask : rd

    function automatic void model(logic [11:0] p, int k, output logic [8:0] cfg,
                                  output logic [31:0] bm, an, ct);
        logic fx, ae, hi, lo;
        logic [4:0] ad;
        fx = p[4 + k];
        ae = p[6 + 3 * k];
        hi = p[7 + 3 * k];
        lo = p[8 + 3 * k];
        ad = {p[3:0], k[0]};
        if (fx)
            bm = 32'h0000_2000 | (32'(lo) << 8);
        else if (ae)
            bm = 32'h0000_3100;
        else
            bm = (32'(hi) << 13) | (32'(lo) << 8);
        case ({fx, hi, lo}) inside
            3'b1?0:  an = 32'h0000_0081;
            3'b1?1:  an = 32'h0000_0101;
            3'b000:  an = 32'h0000_0021;
            3'b001:  an = 32'h0000_0041;
            3'b010:  an = 32'h0000_0081;
            default: an = ae ? 32'h0000_01E1 : 32'h0000_0101;
        endcase
        cfg = {ad, fx, bm[12], bm[13], bm[8]};
        ct = 32'(ad) | (32'(fx) << 8) | (32'({fx, ae, hi, lo}) << 12);
    endfunction : model

    task automatic check_all(logic [11:0] p, logic v);
        logic [8:0]  cfg;
        logic [31:0] bm, an, ct;
        for (int k = 0; k < 2; k++) begin
            model(p, k, cfg, bm, an, ct);
            chk_cfg("portCfg", cfg, portCfg[k]);
            rd("ctrl", 8'(k * 16), ct, 1'b0);
            rd("bmcr", 8'(k * 16 + 4), bm, 1'b0);
            rd("anar", 8'(k * 16 + 8), an, 1'b0);
        end
        rd("status", `SOL_OFS_STATUS, {30'h0, 1'b1, v}, 1'b0);
        chk_reg("strapValid", 32'(v), 32'(strapValid));
    endtask : check_all

    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        stop_test;
    end

    initial begin
        logic [11:0] p;
        logic [8:0]  cfg;
        logic [31:0] bm, an, ct, w;
        int          len;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        strapPinIn = `SOL_PIN_DEFAULT;
        funcPinOut = 12'h000;
        void'($urandom(41));
        // first pass is the unstrapped board, one pass has a too-short reset
        for (int i = 0; i < 14; i++) begin
            p = (i == 0) ? `SOL_PIN_DEFAULT : 12'($urandom);
            len = (i == 5) ? 6 : 20;
            @(posedge mclk);
            rst_b <= 1'b0;
            strapPinIn <= p;
            repeat (len) @(posedge mclk);
            rst_b <= 1'b1;
            repeat (3) @(posedge mclk);
            strapPinIn <= 12'($urandom);
            funcPinOut <= 12'($urandom);
            check_all(p, len >= 20);
        end
        model(p, 0, cfg, bm, an, ct);
        w = $urandom & 32'h0000_7FFF;
        wr(`SOL_OFS_BMCR_A, w);
        rd("bmcr write", `SOL_OFS_BMCR_A, p[4] ? 32'h0000_2000 | (w & 32'h0000_0100) :
           w & 32'h0000_3100, 1'b0);
        wr(`SOL_OFS_ANAR_A, w);
        rd("anar write", `SOL_OFS_ANAR_A, (w & 32'h0000_01E0) | 32'h0000_0001, 1'b0);
        wr(`SOL_OFS_BMCR_A, 32'h0000_8000);
        rd("bmcr restore", `SOL_OFS_BMCR_A, bm, 1'b0);
        wr(`SOL_OFS_CTRL_A, w);
        rd("ctrl readonly", `SOL_OFS_CTRL_A, ct, 1'b0);
        rd("unmapped", 8'h24, 32'h0000_0000, 1'b1);
        stop_test;
    end
endmodule : sol_strap_latch_tb
